// ==== dcr_register_bank.v ====
// Configuration and action register bank of a voltage-output converter.
// Assumes a serial front end that delivers one-cycle 16-bit register
// writes and reads on clk_in, and a general input pin from outside.
// Behaviour
// RL1 - Pin function field selects margin or power role.
// RL2 - Lock bit locks; only unlock code releases.
// RL3 - Code 0101 in action top nibble unlocks.
// RL4 - PMBus bit switches interface to PMBus mode.
// RL5 - Waveform field selects generator waveform type.
// RL6 - Slew step and rate fields drive generator.
// RL7 - Power field 00 powers output up.
// RL8 - Reference enable bit; gain field selects gain.
// RL9 - Address field sets serial bus address.
// RL10 - Alarm bits raise high or medium alarms.
// RL11 - Host writes zeros to reserved bits.
// RL12 - Three fields set alarm burst timing.
// RL13 - Action bit 10 enables the input pin.
// RL14 - Action bit 9 loads factory values.
// RL15 - Action bit 8 enables continuous waveform.
// RL16 - Bits 7 and 6 issue margin commands.
// RL17 - Bit 5 reloads registers from nonvolatile.
// RL18 - Bit 4 stores registers to nonvolatile.
// RL19 - Code 1010 in low nibble resets registers.
// RL20 - Margin high code is bits 11 to 2.
// RL21 - Margin low code is bits 11 to 2.
// RL22 - Pin level selects margin high or low.
// RL23 - Power role stays down until pin pulse.
// RL24 - Programmed image reloads after every reset.
// RL25 - Action bits self-clear and read zero; pin enable and waveform enable stay set here.
// RL26 - Input pin synchronised before use.
`timescale 1ns/100ps
`include "dcr_consts.vh"
module dcr_register_bank (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        wr_en_in,
	input  wire [7:0]  addr_in,
	input  wire [15:0] wr_data_in,
	input  wire        rd_en_in,
	output reg  [15:0] rd_data_out,
	output reg         rd_valid_out,
	output wire        busy_out,
	input  wire        general_input_pin_in,
	output wire [1:0]  waveform_out,
	output wire        locked_out,
	output wire        pmbus_mode_out,
	output wire [2:0]  slew_step_out,
	output wire [3:0]  slew_rate_out,
	output wire        powered_up_out,
	output wire        ref_enable_out,
	output wire [1:0]  ref_gain_out,
	output wire [1:0]  bus_address_out,
	output wire        alarm_high_out,
	output wire        alarm_medium_out,
	output wire [5:0]  alarm_timing_out,
	output reg         wave_enable_out,
	output reg  [9:0]  active_code_out,
	output reg         margin_high_cmd_out,
	output reg         margin_low_cmd_out
);
	// Reload sequencer states.
	localparam ST_IDLE  = 2'h0;
	localparam ST_LOAD  = 2'h1;
	localparam ST_STORE = 2'h2;

	reg  [15:0] main_cfg;       // Main configuration word.
	reg  [15:0] pin_cfg;        // Pin and alarm configuration word.
	reg  [9:0]  margin_high;    // Margin high code.
	reg  [9:0]  margin_low;     // Margin low code.
	reg         pin_enable;     // Input pin is allowed to act.
	reg         nv_valid;       // Image has been programmed once.
	reg  [1:0]  state;          // Sequencer state.
	reg  [2:0]  step;           // Word index plus read latency slot.
	reg         pwr_latched;    // Power role: converter switched on.
	reg         pin_prev;       // Previous synchronised pin level.
	reg         boot_pending;   // Reload owed after reset.
	wire        pin_level;      // Synchronised pin level.
	wire [15:0] nv_rd_data;     // Image read word.
	reg  [15:0] nv_wr_data;     // Image write word.
	wire        nv_wr_en;       // Image write strobe.
	wire [2:0]  pin_func;       // Configured pin role.
	wire        locked;         // Configuration writes blocked.
	wire        act_wr;         // Write to action control this cycle.

	// Pin passes the three-stage synchroniser before any use.
	dcr_input_sync u_sync (                  // see RL26
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.pin_in    (general_input_pin_in),
		.level_out (pin_level)
	);

	// Image of the four configuration words, indexed by step.
	dcr_nv_store #(.WORDS(`DCR_NV_WORDS)) u_nv (
		.clk_in      (clk_in),
		.wr_en_in    (nv_wr_en),
		.wr_addr_in  (step[1:0]),
		.wr_data_in  (nv_wr_data),
		.rd_addr_in  (step[1:0]),
		.rd_data_out (nv_rd_data)
	);

	assign nv_wr_en = (state == ST_STORE);
	assign busy_out = (state != ST_IDLE) | boot_pending;
	assign locked   = main_cfg[`DCR_MAIN_LOCK];
	assign act_wr   = wr_en_in && (addr_in == `DCR_ADDR_ACTION) && !busy_out;
	assign pin_func = pin_cfg[`DCR_PIN_FUNC_HI:`DCR_PIN_FUNC_LO];

	// Select the word to store for the current index.
	always @* begin
		case (step[1:0])
			2'h0:    nv_wr_data = main_cfg;
			2'h1:    nv_wr_data = pin_cfg;
			2'h2:    nv_wr_data = {4'h0, margin_high, 2'h0};
			default: nv_wr_data = {4'h0, margin_low, 2'h0};
		endcase
	end

	// Registers, action decoding and reload sequencer.
	always @(posedge clk_in) begin
		if (rst_in) begin
			main_cfg            <= `DCR_RST_MAIN_CFG;
			pin_cfg             <= `DCR_RST_PIN_CFG;
			margin_high         <= `DCR_RST_MARGIN;
			margin_low          <= `DCR_RST_MARGIN;
			pin_enable          <= 1'b0;
			wave_enable_out     <= 1'b0;
			margin_high_cmd_out <= 1'b0;
			margin_low_cmd_out  <= 1'b0;
			state               <= ST_IDLE;
			step                <= 3'h0;
			boot_pending        <= 1'b1;
		end else begin
			// Commands are single-cycle pulses; only the pin and waveform enables are stored.
			margin_high_cmd_out <= 1'b0;             // see RL25
			margin_low_cmd_out  <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (boot_pending) begin
					boot_pending <= 1'b0;
					if (nv_valid) begin
						state <= ST_LOAD;            // see RL24
						step  <= 3'h0;
					end
				end else if (wr_en_in) begin
					// Configuration writes are refused while locked.
					if (addr_in == `DCR_ADDR_MAIN_CFG && !locked) begin
						main_cfg <= wr_data_in;      // see RL2
					end
					if (addr_in == `DCR_ADDR_PIN_CFG && !locked) begin
						// Reserved bits are held at zero whatever arrives.
						pin_cfg <= wr_data_in & `DCR_PIN_RSVD_MASK; // see RL11
					end
					if (addr_in == `DCR_ADDR_MARGIN_HIGH && !locked) begin
						margin_high <= wr_data_in[`DCR_CODE_HI:`DCR_CODE_LO];
					end                              // see RL20
					if (addr_in == `DCR_ADDR_MARGIN_LOW && !locked) begin
						margin_low <= wr_data_in[`DCR_CODE_HI:`DCR_CODE_LO];
					end                              // see RL21
					if (act_wr) begin
						// Unlock pattern clears the lock bit.
						if (wr_data_in[`DCR_ACT_UNLOCK_HI:`DCR_ACT_UNLOCK_LO]
								== `DCR_UNLOCK_CODE) begin
							main_cfg[`DCR_MAIN_LOCK] <= 1'b0; // see RL3
						end
						if (!locked) begin
							pin_enable <= wr_data_in[`DCR_ACT_PIN_EN]; // see RL13
							wave_enable_out <=
								wr_data_in[`DCR_ACT_WAVE_EN]; // see RL15
							margin_high_cmd_out <=
								wr_data_in[`DCR_ACT_MARGIN_HIGH]; // see RL16
							margin_low_cmd_out <=
								wr_data_in[`DCR_ACT_MARGIN_LOW];
							if (wr_data_in[`DCR_ACT_FACTORY]) begin
								main_cfg    <= `DCR_RST_MAIN_CFG; // see RL14
								pin_cfg     <= `DCR_RST_PIN_CFG;
								margin_high <= `DCR_RST_MARGIN;
								margin_low  <= `DCR_RST_MARGIN;
							end else if (wr_data_in[`DCR_ACT_NV_STORE]) begin
								state <= ST_STORE;           // see RL18
								step  <= 3'h0;
							end else if (wr_data_in[`DCR_ACT_NV_LOAD] ||
									wr_data_in[`DCR_ACT_RESET_HI:
									`DCR_ACT_RESET_LO] == `DCR_RESET_CODE) begin
								// Reset to image, or defaults if unprogrammed.
								if (nv_valid) begin
									state <= ST_LOAD;    // see RL17 see RL19
									step  <= 3'h0;
								end else begin
									main_cfg    <= `DCR_RST_MAIN_CFG;
									pin_cfg     <= `DCR_RST_PIN_CFG;
									margin_high <= `DCR_RST_MARGIN;
									margin_low  <= `DCR_RST_MARGIN;
								end
							end
						end
					end
				end
			end
			ST_LOAD: begin
				// Read data lags the index by one cycle.
				step <= step + 3'h1;
				if (step != 3'h0) begin
					case (step[1:0] - 2'h1)
						2'h0:    main_cfg    <= nv_rd_data;
						2'h1:    pin_cfg     <= nv_rd_data;
						2'h2:    margin_high <=
							nv_rd_data[`DCR_CODE_HI:`DCR_CODE_LO];
						default: margin_low  <=
							nv_rd_data[`DCR_CODE_HI:`DCR_CODE_LO];
					endcase
				end
				if (step == 3'h4) begin
					state <= ST_IDLE;
				end
			end
			ST_STORE: begin
				step <= step + 3'h1;
				if (step == 3'h3) begin
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// Image-programmed flag survives the block reset, like the array.
	initial nv_valid = 1'b0;
	always @(posedge clk_in) begin
		if (state == ST_STORE && step == 3'h3) begin
			nv_valid <= 1'b1;
		end
	end

	// Power role: off after start-up until a rising pin edge arrives.
	always @(posedge clk_in) begin
		if (rst_in) begin
			pwr_latched <= 1'b0;
			pin_prev    <= 1'b0;
		end else begin
			pin_prev <= pin_level;
			if (pin_level && !pin_prev && pin_enable) begin
				pwr_latched <= 1'b1;                 // see RL23
			end else if (!pin_level) begin
				// A low pin powers the converter down again, so a
				// comparator feeding the pin can switch itself off.
				pwr_latched <= 1'b0;                 // see RL1
			end
		end
	end

	// Margin role: pin level picks the high or low code.
	always @(posedge clk_in) begin
		if (rst_in) begin
			active_code_out <= 10'h000;
		end else if (pin_enable && pin_func == `DCR_FUNC_MARGIN) begin
			active_code_out <= pin_level ? margin_high : margin_low; // see RL22
		end else begin
			active_code_out <= margin_low;
		end
	end

	// Register read port; action control always reads as zero.
	always @(posedge clk_in) begin
		if (rst_in) begin
			rd_data_out  <= 16'h0000;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_en_in;
			case (addr_in)
				`DCR_ADDR_MAIN_CFG:    rd_data_out <= main_cfg;
				`DCR_ADDR_PIN_CFG:     rd_data_out <= pin_cfg;
				`DCR_ADDR_MARGIN_HIGH: rd_data_out <= {4'h0, margin_high, 2'h0};
				`DCR_ADDR_MARGIN_LOW:  rd_data_out <= {4'h0, margin_low, 2'h0};
				default:               rd_data_out <= 16'h0000; // see RL25
			endcase
		end
	end

	// Field decoding to the analogue and interface sections.
	assign waveform_out     =                                   // see RL5
		main_cfg[`DCR_MAIN_WAVE_HI:`DCR_MAIN_WAVE_LO];
	assign locked_out       = locked;                       // see RL2
	assign pmbus_mode_out   = main_cfg[`DCR_MAIN_PMBUS];    // see RL4
	assign slew_step_out    =                                   // see RL6
		main_cfg[`DCR_MAIN_STEP_HI:`DCR_MAIN_STEP_LO];
	assign slew_rate_out    =                                   // see RL6
		main_cfg[`DCR_MAIN_RATE_HI:`DCR_MAIN_RATE_LO];
	assign ref_enable_out   = main_cfg[`DCR_MAIN_REF_EN];   // see RL8
	assign ref_gain_out     = main_cfg[`DCR_MAIN_GAIN_HI:`DCR_MAIN_GAIN_LO];
	assign bus_address_out  =                                   // see RL9
		pin_cfg[`DCR_PIN_ADDR_HI:`DCR_PIN_ADDR_LO];
	assign alarm_high_out   = pin_cfg[`DCR_PIN_ALARM_HIGH]; // see RL10
	assign alarm_medium_out = pin_cfg[`DCR_PIN_ALARM_MED1] |
		pin_cfg[`DCR_PIN_ALARM_MED0];
	assign alarm_timing_out = pin_cfg[5:0];                 // see RL12
	// Field powers up at 00; power role further gates it on the pin.
	assign powered_up_out   = (main_cfg[`DCR_MAIN_PWR_HI:`DCR_MAIN_PWR_LO]
		== `DCR_PWR_UP) &&                                  // see RL7
		!(pin_enable && pin_func == `DCR_FUNC_POWER && !pwr_latched); // see RL1
	// Waveform type and slew fields feed the generator outputs unchanged.
endmodule

// ==== dcr_consts.vh ====
// Constants of the converter configuration register bank.
// Assumes inclusion by bare name from each design file of the block that uses its names.
`ifndef DCR_CONSTS_VH
`define DCR_CONSTS_VH
// Register addresses on the serial register port.
`define DCR_ADDR_MARGIN_HIGH  8'h25
`define DCR_ADDR_MARGIN_LOW   8'h26
`define DCR_ADDR_MAIN_CFG     8'hD1
`define DCR_ADDR_PIN_CFG      8'hD2
`define DCR_ADDR_ACTION       8'hD3
// Factory reset values.
`define DCR_RST_MAIN_CFG      16'h0000
`define DCR_RST_PIN_CFG       16'h0000
`define DCR_RST_MARGIN        10'h000
// Main configuration fields.
`define DCR_MAIN_WAVE_HI      15
`define DCR_MAIN_WAVE_LO      14
`define DCR_MAIN_LOCK         13
`define DCR_MAIN_PMBUS        12
`define DCR_MAIN_STEP_HI      11
`define DCR_MAIN_STEP_LO      9
`define DCR_MAIN_RATE_HI      8
`define DCR_MAIN_RATE_LO      5
`define DCR_MAIN_PWR_HI       4
`define DCR_MAIN_PWR_LO       3
`define DCR_MAIN_REF_EN       2
`define DCR_MAIN_GAIN_HI      1
`define DCR_MAIN_GAIN_LO      0
`define DCR_PWR_UP            2'h0
// Pin and alarm configuration fields.
`define DCR_PIN_ADDR_HI       15
`define DCR_PIN_ADDR_LO       14
`define DCR_PIN_FUNC_HI       13
`define DCR_PIN_FUNC_LO       11
`define DCR_PIN_ALARM_HIGH    10
`define DCR_PIN_ALARM_MED1    9
`define DCR_PIN_ALARM_MED0    8
`define DCR_PIN_RSVD_MASK     16'hFF3F
`define DCR_FUNC_MARGIN       3'h2
`define DCR_FUNC_POWER        3'h1
// Action control fields.
`define DCR_ACT_UNLOCK_HI     15
`define DCR_ACT_UNLOCK_LO     12
`define DCR_ACT_PIN_EN        10
`define DCR_ACT_FACTORY       9
`define DCR_ACT_WAVE_EN       8
`define DCR_ACT_MARGIN_HIGH   7
`define DCR_ACT_MARGIN_LOW    6
`define DCR_ACT_NV_LOAD       5
`define DCR_ACT_NV_STORE      4
`define DCR_ACT_RESET_HI      3
`define DCR_ACT_RESET_LO      0
`define DCR_UNLOCK_CODE       4'h5
`define DCR_RESET_CODE        4'hA
// Margin code position.
`define DCR_CODE_HI           11
`define DCR_CODE_LO           2
// Nonvolatile image word count.
`define DCR_NV_WORDS          4
`endif

// ==== dcr_input_sync.v ====
// Three-stage synchroniser with agreement filter for an external pin.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module dcr_input_sync (
	input  wire clk_in,
	input  wire rst_in,
	input  wire pin_in,
	output reg  level_out
);
	// Stage one feeds stage two only; stages two and three are compared.
	reg stage_one;
	reg stage_two;
	reg stage_three;

	// Shift the pin in and accept a change once stages two and three agree.
	always @(posedge clk_in) begin
		if (rst_in) begin
			stage_one   <= 1'b0;
			stage_two   <= 1'b0;
			stage_three <= 1'b0;
			level_out   <= 1'b0;
		end else begin
			stage_one   <= pin_in;
			stage_two   <= stage_one;
			stage_three <= stage_two;
			if (stage_two == stage_three) begin
				level_out <= stage_three;
			end
		end
	end
endmodule

// ==== dcr_nv_store.v ====
// Small register image standing in for the nonvolatile memory.
// Assumes one clock; the contents survive the block's synchronous reset.
`timescale 1ns/100ps
`include "dcr_consts.vh"
module dcr_nv_store #(
	parameter WORDS = `DCR_NV_WORDS
) (
	input  wire        clk_in,
	input  wire        wr_en_in,
	input  wire [1:0]  wr_addr_in,
	input  wire [15:0] wr_data_in,
	input  wire [1:0]  rd_addr_in,
	output reg  [15:0] rd_data_out
);
	// Image words, kept across resets as a real nonvolatile array would be.
	reg [15:0] mem [0:WORDS-1];
	integer    i;

	// Clear the image at start of simulation; it models an erased array.
	initial begin
		for (i = 0; i < WORDS; i = i + 1) begin
			mem[i] = 16'h0000;
		end
		rd_data_out = 16'h0000;
	end

	// Write one word and register the read word on every edge.
	always @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

// ==== dcr_register_bank_checker.sv ====
// Checker for the register bank: lock, fields, actions and reads.
// Assumes it is bound to dcr_register_bank and sees its ports only.
`timescale 1ns/100ps
`include "dcr_consts.vh"
module dcr_register_bank_checker (
	input wire        clk_in,
	input wire        rst_in,
	input wire        wr_en_in,
	input wire [7:0]  addr_in,
	input wire [15:0] wr_data_in,
	input wire        rd_en_in,
	input wire [15:0] rd_data_out,
	input wire        rd_valid_out,
	input wire        busy_out,
	input wire [1:0]  waveform_out,
	input wire        locked_out,
	input wire        pmbus_mode_out,
	input wire        alarm_high_out,
	input wire        alarm_medium_out,
	input wire        wave_enable_out,
	input wire        margin_high_cmd_out,
	input wire        margin_low_cmd_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// A write that the bank must take: idle and unlocked.
	sequence s_wr(a);
		!busy_out && !locked_out && wr_en_in && addr_in == a;
	endsequence
	// An accepted action word without the factory reload.
	sequence s_act;
		s_wr(`DCR_ADDR_ACTION) ##0 !wr_data_in[9];
	endsequence
	lock_set_a: assert property (
		s_wr(`DCR_ADDR_MAIN_CFG) |=> locked_out == $past(wr_data_in[13]))
		else $error("Lock bit not taken from the write.");
	lock_hold_a: assert property (
		!busy_out && locked_out && wr_en_in
		&& addr_in == `DCR_ADDR_MAIN_CFG |=> locked_out)
		else $error("Locked bank dropped its lock.");
	unlock_code_a: assert property (
		!busy_out && wr_en_in && addr_in == `DCR_ADDR_ACTION
		&& wr_data_in[15:12] == `DCR_UNLOCK_CODE |=> !locked_out)
		else $error("Unlock code did not unlock.");
	main_fields_a: assert property (
		s_wr(`DCR_ADDR_MAIN_CFG) |=> pmbus_mode_out == $past(wr_data_in[12])
		&& waveform_out == $past(wr_data_in[15:14]))
		else $error("Mode or waveform field not taken.");
	alarm_flags_a: assert property (
		s_wr(`DCR_ADDR_PIN_CFG) |=> alarm_high_out == $past(wr_data_in[10])
		&& alarm_medium_out == $past(wr_data_in[9] | wr_data_in[8]))
		else $error("Alarm flags do not follow the write.");
	wave_start_a: assert property (
		s_act ##0 wr_data_in[8] |=> wave_enable_out)
		else $error("Waveform mode not enabled.");
	margin_cmd_a: assert property (
		s_act |=> {margin_high_cmd_out, margin_low_cmd_out}
		== $past(wr_data_in[7:6]))
		else $error("Margin command pulse wrong.");
	cmd_cause_a: assert property (
		margin_high_cmd_out || margin_low_cmd_out
		|-> $past(wr_en_in && addr_in == `DCR_ADDR_ACTION))
		else $error("Margin command without an action write.");
	action_read_a: assert property (
		rd_en_in && addr_in == `DCR_ADDR_ACTION
		|=> rd_valid_out && rd_data_out == 16'h0000)
		else $error("Action register did not read zero.");
	nv_busy_a: assert property (
		s_act ##0 wr_data_in[5:4] != 2'h0 |=> busy_out[*2])
		else $error("Store or reload did not hold busy.");
endmodule

// ==== dcr_host_model.sv ====
// Serial host stand-in issuing one-cycle register writes and reads.
// Assumes the bank samples its strobes on the rising clock edge.
`timescale 1ns/100ps
`include "dcr_consts.vh"
module dcr_host_model (
	input  wire        clk_in,
	output reg         wr_en_out,
	output reg  [7:0]  addr_out,
	output reg  [15:0] wr_data_out,
	output reg         rd_en_out,
	input  wire [15:0] rd_data_in,
	input  wire        rd_valid_in
);
	// Quiet bus from time zero.
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = 8'h00;
		wr_data_out = 16'h0000;
	end
	// One write; lines released to the inverse of the last value.
	task wr(input [7:0] a, input [15:0] d);
		begin
			@(negedge clk_in);
			wr_en_out = 1'b1;
			addr_out = a;
			wr_data_out = (a == `DCR_ADDR_PIN_CFG) ?
				(d & `DCR_PIN_RSVD_MASK) : d;
			@(negedge clk_in);
			wr_en_out = 1'b0;
			addr_out = ~addr_out;
			wr_data_out = ~wr_data_out;
		end
	endtask
	// One read; the answer is taken one cycle after the strobe.
	task rd(input [7:0] a, output [15:0] d, output v);
		begin
			@(negedge clk_in);
			rd_en_out = 1'b1;
			addr_out = a;
			@(negedge clk_in);
			rd_en_out = 1'b0;
			addr_out = ~addr_out;
			d = rd_data_in;
			v = rd_valid_in;
		end
	endtask
endmodule

// ==== dac_config_register_bank_tb_top.sv ====
// Self-checking bench for the register bank and its host model.
// Assumes the design files and the checker are compiled alongside.
`timescale 1ns/100ps
`include "dcr_consts.vh"
module dac_config_register_bank_tb_top;
	reg         clk_in;
	reg         rst_in;
	reg         general_input_pin_in;
	wire        wr_en_in, rd_en_in, rd_valid_out, busy_out, locked_out;
	wire        pmbus_mode_out, powered_up_out, ref_enable_out;
	wire        alarm_high_out, alarm_medium_out, wave_enable_out;
	wire        margin_high_cmd_out, margin_low_cmd_out;
	wire [1:0]  waveform_out, ref_gain_out, bus_address_out;
	wire [2:0]  slew_step_out;
	wire [3:0]  slew_rate_out;
	wire [5:0]  alarm_timing_out;
	wire [7:0]  addr_in;
	wire [9:0]  active_code_out;
	wire [15:0] wr_data_in, rd_data_out;
	integer     n_errors, checked;
	reg  [15:0] rd;
	reg         rv;
	dcr_host_model host (
		.clk_in      (clk_in),
		.wr_en_out   (wr_en_in),
		.addr_out    (addr_in),
		.wr_data_out (wr_data_in),
		.rd_en_out   (rd_en_in),
		.rd_data_in  (rd_data_out),
		.rd_valid_in (rd_valid_out)
	);
	dcr_register_bank dut (.*);
	// Counts a comparison and reports a mismatch at once.
	task chk(input string what, input [15:0] exp, input [15:0] got);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	// Reads a register and compares valid flag and data.
	task rdchk(input [7:0] a, input [15:0] exp);
		begin
			host.rd(a, rd, rv);
			chk("rd_valid", 16'h0001, {15'h0000, rv});
			chk("rd_data", exp, rd);
		end
	endtask
	// Waits, bounded, until the bank is no longer busy.
	task idle;
		integer i;
		begin
			for (i = 0; i < 50 && busy_out !== 1'b0; i = i + 1)
				@(negedge clk_in);
			chk("not_busy", 16'h0000, {15'h0000, busy_out});
		end
	endtask
	// Prints the counts and the verdict, then stops the run.
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task t_defaults;
		begin
			rdchk(`DCR_ADDR_MAIN_CFG, 16'h0000);
			rdchk(`DCR_ADDR_PIN_CFG, 16'h0000);
			rdchk(8'h00, 16'h0000);
			chk("powered_up", 16'h0001, powered_up_out);
			$display("test defaults done");
		end
	endtask
	task t_main;
		begin
			host.wr(`DCR_ADDR_MAIN_CFG, 16'h9B6E);
			chk("waveform", 16'h0002, waveform_out);
			chk("pmbus", 16'h0001, pmbus_mode_out);
			chk("step", 16'h0005, slew_step_out);
			chk("rate", 16'h000B, slew_rate_out);
			chk("powered_up", 16'h0000, powered_up_out);
			chk("ref_en", 16'h0001, ref_enable_out);
			chk("gain", 16'h0002, ref_gain_out);
			rdchk(`DCR_ADDR_MAIN_CFG, 16'h9B6E);
			host.wr(`DCR_ADDR_MAIN_CFG, 16'h0000);
			chk("powered_up", 16'h0001, powered_up_out);
			chk("ref_en", 16'h0000, ref_enable_out);
			$display("test main configuration done");
		end
	endtask
	task t_pin;
		begin
			host.wr(`DCR_ADDR_PIN_CFG, 16'hC73F);
			chk("bus_addr", 16'h0003, bus_address_out);
			chk("alarm_high", 16'h0001, alarm_high_out);
			chk("alarm_med", 16'h0001, alarm_medium_out);
			chk("timing", 16'h003F, alarm_timing_out);
			rdchk(`DCR_ADDR_PIN_CFG, 16'hC73F);
			host.wr(`DCR_ADDR_PIN_CFG, 16'h4100);
			chk("bus_addr", 16'h0001, bus_address_out);
			chk("alarm_high", 16'h0000, alarm_high_out);
			chk("alarm_med", 16'h0001, alarm_medium_out);
			$display("test pin configuration done");
		end
	endtask
	task t_lock;
		begin
			host.wr(`DCR_ADDR_MAIN_CFG, 16'h2000);
			chk("locked", 16'h0001, locked_out);
			host.wr(`DCR_ADDR_MAIN_CFG, 16'h0000);
			rdchk(`DCR_ADDR_MAIN_CFG, 16'h2000);
			host.wr(`DCR_ADDR_ACTION, 16'h5000);
			chk("locked", 16'h0000, locked_out);
			$display("test lock done");
		end
	endtask
	task t_margin;
		begin
			host.wr(`DCR_ADDR_PIN_CFG, 16'h1000);
			host.wr(`DCR_ADDR_MARGIN_HIGH, 16'hF99B);
			host.wr(`DCR_ADDR_MARGIN_LOW, 16'hF337);
			host.wr(`DCR_ADDR_ACTION, 16'h0400);
			repeat (6) @(negedge clk_in);
			chk("code_low", 16'h00CD, active_code_out);
			general_input_pin_in = 1'b1;
			@(negedge clk_in);
			chk("code_sync", 16'h00CD, active_code_out);
			repeat (6) @(negedge clk_in);
			chk("code_high", 16'h0266, active_code_out);
			general_input_pin_in = 1'b0;
			$display("test margin role done");
		end
	endtask
	task t_power;
		begin
			host.wr(`DCR_ADDR_PIN_CFG, 16'h0800);
			host.wr(`DCR_ADDR_ACTION, 16'h0400);
			repeat (6) @(negedge clk_in);
			chk("held_off", 16'h0000, powered_up_out);
			general_input_pin_in = 1'b1;
			repeat (6) @(negedge clk_in);
			chk("pulse_on", 16'h0001, powered_up_out);
			general_input_pin_in = 1'b0;
			repeat (6) @(negedge clk_in);
			chk("pulse_off", 16'h0000, powered_up_out);
			host.wr(`DCR_ADDR_PIN_CFG, 16'h0000);
			$display("test power role done");
		end
	endtask
	task t_actions;
		begin
			host.wr(`DCR_ADDR_ACTION, 16'h0100);
			chk("wave_en", 16'h0001, wave_enable_out);
			host.wr(`DCR_ADDR_ACTION, 16'h0080);
			chk("cmd_high", 16'h0001, margin_high_cmd_out);
			host.wr(`DCR_ADDR_ACTION, 16'h0040);
			chk("cmd_high", 16'h0000, margin_high_cmd_out);
			chk("cmd_low", 16'h0001, margin_low_cmd_out);
			rdchk(`DCR_ADDR_ACTION, 16'h0000);
			host.wr(`DCR_ADDR_MAIN_CFG, 16'h0018);
			host.wr(`DCR_ADDR_ACTION, 16'h0010);
			idle;
			host.wr(`DCR_ADDR_MAIN_CFG, 16'h0000);
			host.wr(`DCR_ADDR_ACTION, 16'h0020);
			idle;
			rdchk(`DCR_ADDR_MAIN_CFG, 16'h0018);
			host.wr(`DCR_ADDR_ACTION, 16'h0200);
			idle;
			rdchk(`DCR_ADDR_MAIN_CFG, 16'h0000);
			host.wr(`DCR_ADDR_ACTION, 16'h000A);
			idle;
			rdchk(`DCR_ADDR_MAIN_CFG, 16'h0018);
			host.wr(`DCR_ADDR_MAIN_CFG, 16'h0000);
			@(negedge clk_in);
			rst_in = 1'b1;
			repeat (3) @(negedge clk_in);
			rst_in = 1'b0;
			idle;
			rdchk(`DCR_ADDR_MAIN_CFG, 16'h0018);
			$display("test actions done");
		end
	endtask
	// Free-running clock of 8 ns.
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// Main sequence: reset for 20 cycles, then every scenario.
	initial begin
		n_errors = 0;
		checked = 0;
		rst_in = 1'b1;
		general_input_pin_in = 1'b0;
		repeat (20) @(negedge clk_in);
		rst_in = 1'b0;
		idle;
		t_defaults;
		t_main;
		t_pin;
		t_lock;
		t_margin;
		t_power;
		t_actions;
		end_of_test;
	end
	// Watchdog: the scenarios need well under 500 cycles.
	initial begin
		#20000;
		n_errors = n_errors + 1;
		end_of_test;
	end
endmodule
bind dcr_register_bank dcr_register_bank_checker chk_i (.*);
